//--- core/stat_pkg.sv
/*
 * constants, field layout and carrier types for the chain-port frame statistics bank.
 * assumes one 20 MHz clock and frame event strobes from logic on that same clock.
 */
package stat_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned BYTE_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (byte registers, addressed directly)
    localparam logic [ADDR_W-1:0] OFF_UPPER_RX_VALID_CMD_COUNT_HIGH = 10'h275;
    localparam logic [ADDR_W-1:0] OFF_UPPER_RX_VALID_CMD_COUNT_LOW = 10'h276;
    localparam logic [ADDR_W-1:0] OFF_LOWER_RX_RESPONSE_COUNT_HIGH = 10'h277;
    localparam logic [ADDR_W-1:0] OFF_LOWER_RX_RESPONSE_COUNT_LOW = 10'h278;
    localparam logic [ADDR_W-1:0] OFF_UPPER_TX_FRAME_COUNT_HIGH = 10'h279;
    localparam logic [ADDR_W-1:0] OFF_UPPER_TX_FRAME_COUNT_LOW = 10'h27a;

    ////////////////////////////////////////////////////////////////////////
    // counter slots and values
    localparam int unsigned NUM_CNT = 3;
    localparam int unsigned CNT_CMD = 0;
    localparam int unsigned CNT_RESP = 1;
    localparam int unsigned CNT_TX = 2;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic cmd_frame;
        logic cmd_err;
        logic cmd_crc_ok;
        logic resp_frame;
        logic tx_frame;
    } frame_evt_t;

endpackage

//--- core/sat_count16.sv
/*
 * 16-bit saturating event counter with synchronous restart.
 * assumes inc_i and restart_i come from logic on clk_i.
 */
`timescale 1ns/1ps

module sat_count16
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic inc_i,
    input wire logic restart_i,
    // count
    output logic [stat_pkg::CNT_W-1:0] count_o
);

    logic [stat_pkg::CNT_W-1:0] count_reg;
    logic [stat_pkg::CNT_W-1:0] count_next;

    ////////////////////////////////////////////////////////////////////////
    // an event in the restart cycle is kept, so restart lands on one
    always_comb
    begin
        count_next = count_reg;
        if (restart_i)
        begin
            count_next = inc_i ? stat_pkg::CNT_ONE : stat_pkg::CNT_RESET;
        end
        else if (inc_i && count_reg != stat_pkg::CNT_MAX)
        begin
            count_next = count_reg + stat_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_reg <= stat_pkg::CNT_RESET;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign count_o = count_reg;

endmodule // sat_count16

//--- core/link_frame_stat_counters.sv
/*
 * read-only frame statistics for the two daisy-chain ports: live counters,
 * a snapshot bank latched on a command high-byte read, and the register read port.
 * assumes a plain strobe bus on clk_i and frame strobes on the same clock.
 */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

module link_frame_stat_counters
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire stat_pkg::bus_req_t bus_i,
    output logic [stat_pkg::DATA_W-1:0] rd_data_o,
    // frame events from the chain ports
    input wire stat_pkg::frame_evt_t evt_i
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic hit(input logic [stat_pkg::ADDR_W-1:0] addr, input logic [stat_pkg::ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction

    logic rd_cmd_high;
    logic rd_cmd_low;
    logic [stat_pkg::NUM_CNT-1:0] inc;
    logic [stat_pkg::NUM_CNT-1:0] restart;
    logic [stat_pkg::CNT_W-1:0] cnt [stat_pkg::NUM_CNT];

    // writes have no effect: every register here is read-only
    assign rd_cmd_high = bus_i.rd && hit(bus_i.addr, stat_pkg::OFF_UPPER_RX_VALID_CMD_COUNT_HIGH);
    assign rd_cmd_low = bus_i.rd && hit(bus_i.addr, stat_pkg::OFF_UPPER_RX_VALID_CMD_COUNT_LOW);

    ////////////////////////////////////////////////////////////////////////
    // live counters

    always_comb
    begin
        inc[stat_pkg::CNT_CMD] = evt_i.cmd_frame && !evt_i.cmd_err && evt_i.cmd_crc_ok;
        inc[stat_pkg::CNT_RESP] = evt_i.resp_frame;
        inc[stat_pkg::CNT_TX] = evt_i.tx_frame;
        restart = {stat_pkg::NUM_CNT{rd_cmd_high}};
        restart[stat_pkg::CNT_CMD] = rd_cmd_high || rd_cmd_low;
    end

    genvar gi;
    generate
        for (gi = 0; gi < stat_pkg::NUM_CNT; gi++)
        begin : g_cnt
            sat_count16 u_cnt
            (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .inc_i(inc[gi]),
                .restart_i(restart[gi]),
                .count_o(cnt[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // snapshot bank: one command high-byte read freezes all three; a command low-byte read also restarts the command count alone

    logic [stat_pkg::CNT_W-1:0] snap_reg [stat_pkg::NUM_CNT];
    logic [stat_pkg::CNT_W-1:0] snap_next [stat_pkg::NUM_CNT];

    always_comb
    begin
        for (int i = 0; i < stat_pkg::NUM_CNT; i++)
        begin
            snap_next[i] = rd_cmd_high ? cnt[i] : snap_reg[i];
        end
        if (rd_cmd_low)
        begin
            snap_next[stat_pkg::CNT_CMD][stat_pkg::BYTE_W-1:0] = stat_pkg::REG_RESET;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < stat_pkg::NUM_CNT; i++)
            begin
                snap_reg[i] <= stat_pkg::CNT_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < stat_pkg::NUM_CNT; i++)
            begin
                snap_reg[i] <= snap_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the strobe

    logic [stat_pkg::DATA_W-1:0] rd_data_reg;
    logic [stat_pkg::DATA_W-1:0] rd_data_next;

    always_comb
    begin
        rd_data_next = stat_pkg::UNMAPPED_READ;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                // high byte read shows the fresh latch, not the stale one
                stat_pkg::OFF_UPPER_RX_VALID_CMD_COUNT_HIGH:
                    rd_data_next = cnt[stat_pkg::CNT_CMD][stat_pkg::CNT_W-1:stat_pkg::BYTE_W];
                stat_pkg::OFF_UPPER_RX_VALID_CMD_COUNT_LOW:
                    rd_data_next = snap_reg[stat_pkg::CNT_CMD][stat_pkg::BYTE_W-1:0];
                stat_pkg::OFF_LOWER_RX_RESPONSE_COUNT_HIGH:
                    rd_data_next = snap_reg[stat_pkg::CNT_RESP][stat_pkg::CNT_W-1:stat_pkg::BYTE_W];
                stat_pkg::OFF_LOWER_RX_RESPONSE_COUNT_LOW:
                    rd_data_next = snap_reg[stat_pkg::CNT_RESP][stat_pkg::BYTE_W-1:0];
                stat_pkg::OFF_UPPER_TX_FRAME_COUNT_HIGH:
                    rd_data_next = snap_reg[stat_pkg::CNT_TX][stat_pkg::CNT_W-1:stat_pkg::BYTE_W];
                stat_pkg::OFF_UPPER_TX_FRAME_COUNT_LOW:
                    rd_data_next = snap_reg[stat_pkg::CNT_TX][stat_pkg::BYTE_W-1:0];
                default:
                    rd_data_next = stat_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_data_reg <= stat_pkg::REG_RESET;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data_o = rd_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_cmd_bad_ignored:
    assert property (evt_i.cmd_frame && (evt_i.cmd_err || !evt_i.cmd_crc_ok) && !rd_cmd_high && !rd_cmd_low
        |=> cnt[stat_pkg::CNT_CMD] == $past(cnt[stat_pkg::CNT_CMD]))
    else $error("bad command frame was counted");

    a_cmd_sat_hold:
    assert property (cnt[stat_pkg::CNT_CMD] == stat_pkg::CNT_MAX && !rd_cmd_high && !rd_cmd_low
        |=> cnt[stat_pkg::CNT_CMD] == stat_pkg::CNT_MAX)
    else $error("command counter wrapped");

    a_low_read_clear:
    assert property (rd_cmd_low && !evt_i.cmd_frame
        |=> snap_reg[stat_pkg::CNT_CMD][stat_pkg::BYTE_W-1:0] == stat_pkg::REG_RESET
            && cnt[stat_pkg::CNT_CMD] == stat_pkg::CNT_RESET)
    else $error("low byte read did not clear");

    a_high_read_latch:
    assert property (rd_cmd_high
        |=> snap_reg[stat_pkg::CNT_RESP] == $past(cnt[stat_pkg::CNT_RESP])
            && snap_reg[stat_pkg::CNT_TX] == $past(cnt[stat_pkg::CNT_TX])
            && snap_reg[stat_pkg::CNT_CMD] == $past(cnt[stat_pkg::CNT_CMD])
            && rd_data_o == $past(cnt[stat_pkg::CNT_CMD][stat_pkg::CNT_W-1:stat_pkg::BYTE_W]))
    else $error("snapshot not latched together");

    a_tx_count_step:
    assert property (evt_i.tx_frame && !rd_cmd_high && cnt[stat_pkg::CNT_TX] != stat_pkg::CNT_MAX
        |=> cnt[stat_pkg::CNT_TX] == $past(cnt[stat_pkg::CNT_TX]) + stat_pkg::CNT_ONE)
    else $error("tx counter did not step");

    a_resp_sat_hold:
    assert property (cnt[stat_pkg::CNT_RESP] == stat_pkg::CNT_MAX && !rd_cmd_high
        |=> cnt[stat_pkg::CNT_RESP] == stat_pkg::CNT_MAX)
    else $error("response counter wrapped");

    a_resp_read_data:
    assert property (bus_i.rd && hit(bus_i.addr, stat_pkg::OFF_LOWER_RX_RESPONSE_COUNT_LOW)
        |=> rd_data_o == $past(snap_reg[stat_pkg::CNT_RESP][stat_pkg::BYTE_W-1:0]))
    else $error("response low byte read wrong");

    a_idle_read_zero:
    assert property (!bus_i.rd |=> rd_data_o == stat_pkg::UNMAPPED_READ)
    else $error("read data outside read slot");

    a_cmd_count_step:
    assert property (evt_i.cmd_frame && !evt_i.cmd_err && evt_i.cmd_crc_ok && !rd_cmd_high && !rd_cmd_low
        && cnt[stat_pkg::CNT_CMD] != stat_pkg::CNT_MAX
        |=> cnt[stat_pkg::CNT_CMD] == $past(cnt[stat_pkg::CNT_CMD]) + stat_pkg::CNT_ONE)
    else $error("good command frame not counted");

    a_low_read_data:
    assert property (rd_cmd_low
        |=> rd_data_o == $past(snap_reg[stat_pkg::CNT_CMD][stat_pkg::BYTE_W-1:0]))
    else $error("command low byte read wrong");

    a_high_read_restart:
    assert property (rd_cmd_high && !evt_i.cmd_frame && !evt_i.resp_frame && !evt_i.tx_frame
        |=> cnt[stat_pkg::CNT_CMD] == stat_pkg::CNT_RESET && cnt[stat_pkg::CNT_RESP] == stat_pkg::CNT_RESET
            && cnt[stat_pkg::CNT_TX] == stat_pkg::CNT_RESET)
    else $error("high byte read did not restart all");

    a_tx_sat_hold:
    assert property (cnt[stat_pkg::CNT_TX] == stat_pkg::CNT_MAX && !rd_cmd_high
        |=> cnt[stat_pkg::CNT_TX] == stat_pkg::CNT_MAX)
    else $error("tx counter wrapped");

    a_resp_count_step:
    assert property (evt_i.resp_frame && !rd_cmd_high && cnt[stat_pkg::CNT_RESP] != stat_pkg::CNT_MAX
        |=> cnt[stat_pkg::CNT_RESP] == $past(cnt[stat_pkg::CNT_RESP]) + stat_pkg::CNT_ONE)
    else $error("response counter did not step");

    c_cmd_saturated: cover property (cnt[stat_pkg::CNT_CMD] == stat_pkg::CNT_MAX);
    c_high_then_low: cover property (rd_cmd_high ##1 rd_cmd_low);
    c_restart_with_event: cover property (rd_cmd_high && evt_i.tx_frame);
    c_tx_saturated: cover property (cnt[stat_pkg::CNT_TX] == stat_pkg::CNT_MAX);

endmodule // link_frame_stat_counters

//--- verification/chain_peer_model.sv
/*
 * neighbouring stacked device: makes frame strobes on the chain ports.
 * assumes the bench calls send after a rising edge of clk_i.
 */
`timescale 1ns/1ps

module chain_peer_model
(
    // clock
    input wire logic clk_i,
    // frame strobes toward the block
    output stat_pkg::frame_evt_t evt_o
);
    initial evt_o = '0;

    // strobes held for n edges, then dropped; qualifiers ride with them
    task automatic send(input logic [4:0] mask, input int n);
        @(posedge clk_i);
        evt_o <= mask;
        repeat (n) @(posedge clk_i);
        evt_o <= '0;
    endtask
endmodule // chain_peer_model

//--- verification/test_link_frame_stat_counters.sv
/*
 * self-checking bench for the frame statistics bank.
 * assumes one 20 MHz clock; frame strobes come from chain_peer_model.
 */
`timescale 1ns/1ps

module test_link_frame_stat_counters;
    logic clk_i = 1'b0;
    // left unknown here so the first drive low is a real falling edge
    logic rst_n_i;
    stat_pkg::bus_req_t bus = '0;
    logic [7:0] rd_data;
    stat_pkg::frame_evt_t evt;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    link_frame_stat_counters DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus), .rd_data_o(rd_data), .evt_i(evt));
    chain_peer_model peer (.clk_i(clk_i), .evt_o(evt));

    initial forever #25 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_i);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk_i);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_map();
        logic [7:0] d;
        for (int a = 10'h275; a <= 10'h27b; a++)
        begin
            rd(a[9:0], d);
            check("reset value", d, 8'h00);
        end
        wr(10'h276, 8'haa);
        rd(10'h276, d);
        check("write ignored", d, 8'h00);
        $display("test reset_map done");
    endtask

    task automatic t_qualify_latch();
        logic [7:0] d;
        logic [7:0] exp [6] = '{8'h00, 8'h03, 8'h00, 8'h02, 8'h00, 8'h04};
        peer.send(5'h16, 2);
        peer.send(5'h14, 1);
        peer.send(5'h1c, 1);
        peer.send(5'h10, 1);
        peer.send(5'h01, 4);
        for (int i = 0; i < 6; i++)
        begin
            rd(10'h275 + i[9:0], d);
            check("latched byte", d, exp[i]);
        end
        rd(10'h276, d);
        check("low cleared", d, 8'h00);
        $display("test qualify_latch done");
    endtask

    task automatic t_low_restart();
        logic [7:0] d;
        peer.send(5'h15, 2);
        rd(10'h276, d);
        check("old snapshot low", d, 8'h00);
        peer.send(5'h14, 1);
        rd(10'h275, d);
        check("cmd high", d, 8'h00);
        rd(10'h276, d);
        check("cmd after restart", d, 8'h01);
        rd(10'h27a, d);
        check("tx kept", d, 8'h02);
        $display("test low_restart done");
    endtask

    // all three counters pushed past full at once
    task automatic t_saturate();
        logic [7:0] d;
        peer.send(5'h17, 65540);
        for (int i = 0; i < 6; i++)
        begin
            rd(10'h275 + i[9:0], d);
            check("saturated byte", d, 8'hff);
        end
        $display("test saturate done");
    endtask

    // reset in mid-run must clear live counters and the full snapshots
    task automatic t_midrun_reset();
        logic [7:0] d;
        peer.send(5'h17, 3);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int a = 10'h275; a <= 10'h27a; a++)
        begin
            rd(a[9:0], d);
            check("after reset", d, 8'h00);
        end
        $display("test midrun_reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // ceiling covers the 65540-cycle saturation run with margin
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        rst_n_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset_map();
        t_qualify_latch();
        t_low_restart();
        t_saturate();
        t_midrun_reset();
        conclude();
    end
endmodule // test_link_frame_stat_counters
